// >>> prio_mask_cfg.svh
// Constants for the exception priority masking block.
// Behaviour
// [R1] A set priority mask blocks every configurable-priority exception; clear has no effect.
// [R2] Both mask registers are read and written by special-register move operations.
// [R3] The processor-state-change operation sets or clears either mask bit directly.
// [R4] Each interrupt source has one stored 4-bit priority value.
// [R5] Each priority register packs four fields, one per byte; eight registers cover all.
// [R6] Single bytes are read and written; a byte write changes only its field.
// [R7] Storage exists for interrupt priorities zero through twenty-nine.
// [R8] Byte lane three of each register holds the priority of interrupt 4m+3.
// [R9] Byte lane two of each register holds the priority of interrupt 4m+2.
// [R10] Byte lane one holds interrupt 4m+1, byte lane zero holds interrupt 4m.
// [R11] Only bits 7:4 of each priority byte exist; bits 3:0 read zero.
// [R12] Lower priority values mean greater priority; values run zero to fifteen.
// [R13] Interrupt m sits in register m div 4 at byte lane m mod 4.
// [R14] Priority mask register bits above bit zero read zero and ignore writes.
`ifndef PRIO_MASK_CFG_SVH
`define PRIO_MASK_CFG_SVH

`define IRQ_COUNT        30
`define IPR_COUNT        8
`define PRIO_WIDTH       4
`define PRIO_FIELD_LSB   4
`define MASK_BIT_POS     0
`define MASK_RESET       1'h0
`define IPR_RESET        32'h00000000
`define PRIO_RESET       4'h0

`endif

// >>> prio_mask_pkg.sv
// Types shared by the exception priority masking block.
`default_nettype none
package prio_mask_pkg;
  typedef logic [3:0] prio_t;
  typedef enum logic [0:0] {
    SEL_PRIORITY_MASK = 1'h0,
    SEL_FAULT_MASK    = 1'h1
  } sreg_sel_t;
endpackage
`default_nettype wire

// >>> prio_field_bank.sv
// Byte-addressable storage for the per-interrupt priority fields.
`default_nettype none
`include "prio_mask_cfg.svh"
module prio_field_bank (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Priority register access
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  input  wire logic [2:0]   index_i,
  input  wire logic [3:0]   byte_en_i,
  input  wire logic [31:0]  wdata_i,
  output logic      [31:0]  rdata_o,
  // Stored priorities, field m at bits 4m+3:4m
  output logic      [119:0] prio_o
);

  function automatic logic [4:0] field_of(input logic [2:0] idx, input logic [1:0] lane);
    field_of = {idx, lane};
  endfunction

  // [R4] [R7] [R12] thirty 4-bit fields
  prio_mask_pkg::prio_t mem [0:`IRQ_COUNT-1];
  wire prio_mask_pkg::prio_t field_val [0:31];
  wire logic [31:0] next_rdata;

  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_fields
      // Fields beyond the last interrupt have no storage and read as zero.
      if (g < `IRQ_COUNT)
      begin : g_real
        assign field_val[g]        = mem[g];
        assign prio_o[g*4 +: 4]    = mem[g];
      end
      else
      begin : g_absent
        assign field_val[g] = 4'h0;
      end
    end
    for (g = 0; g < 4; g++)
    begin : g_lanes
      // [R8] [R9] [R10] lane mapping, [R11] low nibble zero
      assign next_rdata[g*8 +: 8] = {field_val[field_of(index_i, 2'(g))], 4'h0};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Field storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < `IRQ_COUNT; i++)
    begin
      // [R6] [R13] per-byte field write
      if (rst_i)
        mem[i] <= `PRIO_RESET;
      else if (wr_i && byte_en_i[i % 4] && (index_i == 3'(i / 4)))
        mem[i] <= wdata_i[(i % 4) * 8 + `PRIO_FIELD_LSB +: `PRIO_WIDTH];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= `IPR_RESET;
    else if (rd_i)
      rdata_o <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_lane0_write: assert property ( // [R6]
    wr_i && byte_en_i[0] && index_i != 3'h7 |=> field_val[field_of($past(index_i), 2'h0)] == $past(wdata_i[7:4]))
    else $error("lane zero write not stored");
  a_lane_untouched: assert property ( // [R6]
    wr_i && !byte_en_i[3] |=> field_val[field_of($past(index_i), 2'h3)] == $past(field_val[field_of(index_i, 2'h3)]))
    else $error("disabled byte lane changed");
  a_low_nibble_zero: assert property ( // [R11]
    (rdata_o & 32'h0F0F0F0F) == 32'h00000000)
    else $error("low nibble of a priority byte not zero");
  a_lane_map_read: assert property ( // [R8] [R9] [R10]
    rd_i ##0 !wr_i |=> rdata_o[31:28] == field_val[field_of($past(index_i), 2'h3)]
                     && rdata_o[23:20] == field_val[field_of($past(index_i), 2'h2)]
                     && rdata_o[15:12] == field_val[field_of($past(index_i), 2'h1)]
                     && rdata_o[7:4] == field_val[field_of($past(index_i), 2'h0)])
    else $error("priority read lane mismatch");
  a_absent_fields: assert property ( // [R7]
    rd_i && index_i == 3'h7 |=> rdata_o[31:16] == 16'h0000)
    else $error("absent interrupt fields not zero");
  c_write_read: cover property (wr_i && byte_en_i == 4'hF ##2 rd_i);

endmodule // prio_field_bank
`default_nettype wire

// >>> exception_priority_masking.sv
// Priority mask, fault mask and interrupt priority storage for the processor.
`default_nettype none
`include "prio_mask_cfg.svh"
module exception_priority_masking (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Special-register moves
  input  wire logic         sreg_wr_i,
  input  wire logic         sreg_rd_i,
  input  wire logic [0:0]   sreg_sel_i,
  input  wire logic [31:0]  sreg_wdata_i,
  output logic      [31:0]  sreg_rdata_o,
  // Processor-state-change operation
  input  wire logic         cps_i,
  input  wire logic [0:0]   cps_sel_i,
  input  wire logic         cps_disable_i,
  // Priority register access
  input  wire logic         ipr_wr_i,
  input  wire logic         ipr_rd_i,
  input  wire logic [2:0]   ipr_index_i,
  input  wire logic [3:0]   ipr_byte_en_i,
  input  wire logic [31:0]  ipr_wdata_i,
  output logic      [31:0]  ipr_rdata_o,
  // Exception activation
  input  wire logic [29:0]  irq_pending_i,
  output logic      [29:0]  irq_activate_o,
  output logic      [119:0] irq_prio_o,
  output logic              priority_mask_o,
  output logic              fault_mask_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic sel_hit(input logic [0:0] sel, input prio_mask_pkg::sreg_sel_t want);
    sel_hit = (sel == want);
  endfunction

  logic priority_mask_bit;
  logic fault_mask_bit;

  wire logic msr_pm   = sreg_wr_i && sel_hit(sreg_sel_i, prio_mask_pkg::SEL_PRIORITY_MASK);
  wire logic msr_fm   = sreg_wr_i && sel_hit(sreg_sel_i, prio_mask_pkg::SEL_FAULT_MASK);
  wire logic cps_pm   = cps_i && sel_hit(cps_sel_i, prio_mask_pkg::SEL_PRIORITY_MASK);
  wire logic cps_fm   = cps_i && sel_hit(cps_sel_i, prio_mask_pkg::SEL_FAULT_MASK);
  // [R2] [R14] only bit zero is taken from a move
  wire logic msr_bit  = sreg_wdata_i[`MASK_BIT_POS];

  // The state-change operation wins if both arrive together, since it is
  // the later-decoded instruction in the pipeline that owns the bit.
  wire logic next_pm  = cps_pm ? cps_disable_i : (msr_pm ? msr_bit : priority_mask_bit);
  wire logic next_fm  = cps_fm ? cps_disable_i : (msr_fm ? msr_bit : fault_mask_bit);

  // [R2] [R14] read value, reserved bits zero
  wire logic next_rd_bit = sel_hit(sreg_sel_i, prio_mask_pkg::SEL_PRIORITY_MASK) ? priority_mask_bit
                                                                                : fault_mask_bit;
  wire logic [31:0] next_sreg_rdata = {31'h00000000, next_rd_bit};

  // Only the priority mask gates activation here. The fault mask is stored
  // and reported, and the ranking logic beyond this block applies it.
  // [R1] configurable exceptions blocked while the mask is set
  wire logic [29:0] next_activate = priority_mask_bit ? 30'h00000000 : irq_pending_i;

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  // Both masks share one process, as moves and state changes reach them
  // through the same selector decode and would otherwise duplicate it.
  always_ff @(posedge clk_i)
  begin
    // [R3] direct set and clear
    if (rst_i)
    begin
      priority_mask_bit <= `MASK_RESET;
      fault_mask_bit    <= `MASK_RESET;
    end
    else
    begin
      priority_mask_bit <= next_pm;
      fault_mask_bit    <= next_fm;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sreg_rdata_o <= 32'h00000000;
    else if (sreg_rd_i)
      sreg_rdata_o <= next_sreg_rdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_activate_o <= 30'h00000000;
    else
      irq_activate_o <= next_activate;
  end

  assign priority_mask_o = priority_mask_bit;
  assign fault_mask_o    = fault_mask_bit;

  // ----------------------------------------------------------------
  // Priority fields
  // ----------------------------------------------------------------
  // [R5] eight packed registers
  prio_field_bank u_bank (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_i      (ipr_wr_i),
    .rd_i      (ipr_rd_i),
    .index_i   (ipr_index_i),
    .byte_en_i (ipr_byte_en_i),
    .wdata_i   (ipr_wdata_i),
    .rdata_o   (ipr_rdata_o),
    .prio_o    (irq_prio_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_mask_blocks_all: assert property ( // [R1]
    priority_mask_bit |=> irq_activate_o == 30'h00000000)
    else $error("activation while priority mask set");
  a_mask_clear_pass: assert property ( // [R1]
    !priority_mask_bit |=> irq_activate_o == $past(irq_pending_i))
    else $error("clear priority mask altered activation");
  a_move_to_mask: assert property ( // [R2]
    msr_pm && !cps_i |=> priority_mask_o == $past(sreg_wdata_i[0]))
    else $error("move to priority mask not applied");
  a_move_from_mask: assert property ( // [R14]
    sreg_rd_i && sreg_sel_i == 1'h0 |=> sreg_rdata_o == {31'h00000000, $past(priority_mask_bit)})
    else $error("priority mask read value wrong");
  a_state_change_pm: assert property ( // [R3]
    cps_pm |=> priority_mask_o == $past(cps_disable_i))
    else $error("state change did not set priority mask");
  a_state_change_fm: assert property ( // [R3]
    cps_fm |=> fault_mask_o == $past(cps_disable_i))
    else $error("state change did not set fault mask");
  a_mask_holds: assert property ( // [R2]
    !sreg_wr_i && !cps_i |=> $stable(priority_mask_o) && $stable(fault_mask_o))
    else $error("mask changed without an access");
  // Both strobes on one mask in one cycle: the state change owns the bit.
  a_cps_beats_move: assert property ( // [R3]
    cps_pm && msr_pm |=> priority_mask_o == $past(cps_disable_i))
    else $error("move overrode a state change");

  // ----------------------------------------------------------------
  // Fault mask and read data checks
  // ----------------------------------------------------------------
  // The fault mask is only stored here, so it must never block on its own.
  a_fault_no_gate: assert property ( // [R1]
    fault_mask_bit && !priority_mask_bit |=> irq_activate_o == $past(irq_pending_i))
    else $error("fault mask blocked activation");
  a_move_to_fault: assert property ( // [R2]
    msr_fm && !cps_fm |=> fault_mask_o == $past(sreg_wdata_i[0]))
    else $error("move to fault mask not applied");
  a_move_from_fault: assert property ( // [R2] [R14]
    sreg_rd_i && sreg_sel_i == 1'h1 |=> sreg_rdata_o == {31'h00000000, $past(fault_mask_bit)})
    else $error("fault mask read value wrong");
  // Read data must hold between reads, since software may sample it late.
  a_sreg_rdata_holds: assert property ( // [R2]
    !sreg_rd_i |=> $stable(sreg_rdata_o))
    else $error("mask read data changed without a read");

  // ----------------------------------------------------------------
  // Priority field checks
  // ----------------------------------------------------------------
  // Field m sits at bits 4m+3:4m of the flat vector, so the bit offset of a
  // lane is the register index and the lane number followed by two zeros.
  a_lane3_visible: assert property ( // [R8] [R13]
    ipr_wr_i && ipr_byte_en_i[3] && ipr_index_i != 3'h7
      |=> irq_prio_o[{$past(ipr_index_i), 2'h3, 2'h0} +: 4] == $past(ipr_wdata_i[31:28]))
    else $error("lane three priority not stored");
  a_lane2_visible: assert property ( // [R9] [R13]
    ipr_wr_i && ipr_byte_en_i[2] && ipr_index_i != 3'h7
      |=> irq_prio_o[{$past(ipr_index_i), 2'h2, 2'h0} +: 4] == $past(ipr_wdata_i[23:20]))
    else $error("lane two priority not stored");
  a_lane1_visible: assert property ( // [R10] [R13]
    ipr_wr_i && ipr_byte_en_i[1]
      |=> irq_prio_o[{$past(ipr_index_i), 2'h1, 2'h0} +: 4] == $past(ipr_wdata_i[15:12]))
    else $error("lane one priority not stored");
  a_lane0_visible: assert property ( // [R10] [R13]
    ipr_wr_i && ipr_byte_en_i[0]
      |=> irq_prio_o[{$past(ipr_index_i), 2'h0, 2'h0} +: 4] == $past(ipr_wdata_i[7:4]))
    else $error("lane zero priority not stored");
  a_prio_holds: assert property ( // [R6]
    !ipr_wr_i |=> $stable(irq_prio_o))
    else $error("priority changed without a write");
  a_ipr_rdata_holds: assert property ( // [R6]
    !ipr_rd_i |=> $stable(ipr_rdata_o))
    else $error("priority read data changed without a read");
  a_other_index_kept: assert property ( // [R13]
    ipr_wr_i && ipr_index_i != 3'h0 |=> irq_prio_o[15:0] == $past(irq_prio_o[15:0]))
    else $error("write reached a register it did not address");

  // ----------------------------------------------------------------
  // Reset checks
  // ----------------------------------------------------------------
  // This check brings its own disable condition, since the default one
  // would switch it off in exactly the cycles that it watches.
  a_reset_clears: assert property ( // [R2] [R4]
    disable iff (1'b0)
    rst_i |=> !priority_mask_o && !fault_mask_o
              && irq_activate_o == 30'h00000000
              && sreg_rdata_o == 32'h00000000
              && ipr_rdata_o == 32'h00000000
              && irq_prio_o == 120'h0)
    else $error("outputs not cleared by reset");

  c_mask_set_block: cover property (cps_pm && cps_disable_i ##1 irq_pending_i != 30'h00000000);
  c_mask_cleared: cover property (priority_mask_bit ##1 !priority_mask_bit);
  c_fault_move: cover property (msr_fm ##2 sreg_rd_i);
  c_prio_byte_write: cover property (ipr_wr_i && ipr_byte_en_i != 4'hF ##2 ipr_rd_i);

endmodule // exception_priority_masking
`default_nettype wire

// >>> exception_priority_masking_tb_top.sv
// Self-checking bench for the exception priority masking block.
`default_nettype none
module exception_priority_masking_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          sreg_wr_i = 1'b0, sreg_rd_i = 1'b0, cps_i = 1'b0, cps_disable_i = 1'b0;
  logic [0:0]    sreg_sel_i = 1'h0, cps_sel_i = 1'h0;
  logic [31:0]   sreg_wdata_i = 32'h0, ipr_wdata_i = 32'h0, sreg_rdata_o, ipr_rdata_o, got, d;
  logic          ipr_wr_i = 1'b0, ipr_rd_i = 1'b0, priority_mask_o, fault_mask_o;
  logic [2:0]    ipr_index_i = 3'h0;
  logic [3:0]    ipr_byte_en_i = 4'h0;
  logic [29:0]   irq_pending_i = 30'h0, irq_activate_o;
  logic [119:0]  irq_prio_o, exp_prio = 120'h0;
  int            num_errors = 0, checks_done = 0;

  exception_priority_masking uut (.clk_i(clk_i), .rst_i(rst_i), .sreg_wr_i(sreg_wr_i), .sreg_rd_i(sreg_rd_i),
    .sreg_sel_i(sreg_sel_i), .sreg_wdata_i(sreg_wdata_i), .sreg_rdata_o(sreg_rdata_o), .cps_i(cps_i),
    .cps_sel_i(cps_sel_i), .cps_disable_i(cps_disable_i), .ipr_wr_i(ipr_wr_i), .ipr_rd_i(ipr_rd_i),
    .ipr_index_i(ipr_index_i), .ipr_byte_en_i(ipr_byte_en_i), .ipr_wdata_i(ipr_wdata_i),
    .ipr_rdata_o(ipr_rdata_o), .irq_pending_i(irq_pending_i), .irq_activate_o(irq_activate_o),
    .irq_prio_o(irq_prio_o), .priority_mask_o(priority_mask_o), .fault_mask_o(fault_mask_o));

  always #4 clk_i = ~clk_i;

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  // Every access ends with an idle edge, so a strobe is never lowered and raised in one time step.
  task automatic step();
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_vec(input string nm, input logic [119:0] e, input logic [119:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic sreg_op(input logic wr, input logic [0:0] sel, input logic [31:0] wd, output logic [31:0] rd);
    sreg_wr_i = wr;
    sreg_rd_i = ~wr;
    sreg_sel_i = sel;
    sreg_wdata_i = wd;
    step();
    sreg_wr_i = 1'b0;
    sreg_rd_i = 1'b0;
    rd = sreg_rdata_o;
    step();
  endtask
  task automatic change_processor_state(input logic [0:0] sel, input logic dis);
    cps_i = 1'b1;
    cps_sel_i = sel;
    cps_disable_i = dis;
    step();
    cps_i = 1'b0;
    step();
  endtask
  // Fields of irq 30 and 31 do not exist, so the model drops them.
  task automatic ipr_write(input logic [2:0] idx, input logic [3:0] en, input logic [31:0] wd);
    ipr_wr_i = 1'b1;
    ipr_index_i = idx;
    ipr_byte_en_i = en;
    ipr_wdata_i = wd;
    for (int k = 0; k < 4; k++)
      if (en[k] && 4 * idx + k < 30)
        exp_prio[(4 * idx + k) * 4 +: 4] = wd[8 * k + 4 +: 4];
    step();
    ipr_wr_i = 1'b0;
    step();
  endtask
  task automatic ipr_check(input int idx);
    logic [31:0] w;
    w = 32'h0;
    for (int k = 0; k < 4; k++)
      if (4 * idx + k < 30)
        w[8 * k + 4 +: 4] = exp_prio[(4 * idx + k) * 4 +: 4];
    ipr_rd_i = 1'b1;
    ipr_index_i = idx[2:0];
    step();
    ipr_rd_i = 1'b0;
    chk_reg("ipr_rdata", w, ipr_rdata_o);
    step();
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    irq_pending_i = 30'h2AAAAAAB;
    chk_vec("prio_reset", 120'h0, irq_prio_o);
    sreg_op(1'b0, 1'h0, 32'h0, got);
    chk_reg("exception_priority_mask_reset", 32'h0, got);
    chk_reg("activate_open", {2'h0, irq_pending_i}, {2'h0, irq_activate_o});
    // Low nibbles written as ones must read back as zero.
    for (int i = 0; i < 8; i++)
    begin
      for (int k = 0; k < 4; k++)
        d[8 * k +: 8] = {4'(4 * i + k + 1), 4'hF};
      ipr_write(i[2:0], 4'hF, d);
      ipr_check(i);
    end
    chk_vec("prio_all", exp_prio, irq_prio_o);
    ipr_write(3'h3, 4'h4, 32'h5AA5A55A);
    ipr_write(3'h7, 4'hC, 32'hF0F00000);
    ipr_check(3);
    ipr_check(7);
    chk_vec("prio_byte", exp_prio, irq_prio_o);
    sreg_op(1'b1, 1'h0, 32'hFFFFFFFF, got);
    step();
    chk_reg("activate_masked", 32'h0, {2'h0, irq_activate_o});
    sreg_op(1'b0, 1'h0, 32'h0, got);
    chk_reg("exception_priority_mask_read", 32'h1, got);
    for (int v = 0; v < 2; v++)
    begin
      change_processor_state(1'h0, v[0]);
      step();
      chk_reg("activate_cps", v ? 32'h0 : {2'h0, irq_pending_i}, {2'h0, irq_activate_o});
      change_processor_state(1'h1, v[0]);
      chk_reg("fault_mask_bit_cps", {31'h0, v[0]}, {31'h0, fault_mask_o});
      sreg_op(1'b1, 1'h1, {31'h7FFFFFFF, ~v[0]}, got);
      sreg_op(1'b0, 1'h1, 32'h0, got);
      chk_reg("fault_mask_bit_read", {31'h0, ~v[0]}, got);
    end
    sreg_op(1'b1, 1'h0, 32'hFFFFFFFE, got);
    chk_reg("exception_priority_mask_clear", 32'h0, {31'h0, priority_mask_o});
    // A state change and a move on the same mask in one cycle: the state change wins.
    sreg_wr_i = 1'b1;
    sreg_sel_i = 1'h0;
    sreg_wdata_i = 32'h00000000;
    cps_i = 1'b1;
    cps_sel_i = 1'h0;
    cps_disable_i = 1'b1;
    step();
    sreg_wr_i = 1'b0;
    cps_i = 1'b0;
    chk_reg("cps_over_move", 32'h1, {31'h0, priority_mask_o});
    step();
    give_verdict();
  end
endmodule // exception_priority_masking_tb_top
`default_nettype wire
